// ==== design/tsw_host.sv ====
// two-wire bus master driven from AXI4-Lite command registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module tsw_host (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// AXI4-Lite slave
	input  wire logic [7:0]  axi_awaddr_in,
	input  wire logic        axi_awvalid_in,
	output logic             axi_awready_out,
	input  wire logic [31:0] axi_wdata_in,
	input  wire logic [3:0]  axi_wstrb_in,
	input  wire logic        axi_wvalid_in,
	output logic             axi_wready_out,
	output logic [1:0]       axi_bresp_out,
	output logic             axi_bvalid_out,
	input  wire logic        axi_bready_in,
	input  wire logic [7:0]  axi_araddr_in,
	input  wire logic        axi_arvalid_in,
	output logic             axi_arready_out,
	output logic [31:0]      axi_rdata_out,
	output logic [1:0]       axi_rresp_out,
	output logic             axi_rvalid_out,
	input  wire logic        axi_rready_in,
	// two-wire link
	tsw_if.host              bus
);
	logic                     awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]               bresp_r, rresp_r;
	logic [31:0]              rdata_r, wdata_h_r;
	logic [3:0]               wstrb_h_r;
	logic [7:0]               awaddr_h_r;
	logic                     aw_got_r, w_got_r;
	logic                     wr_do, go;
	logic [1:0]               sda_sy_r;
	tsw_pkg::tsw_host_state_t st_r;
	logic [7:0]               qcnt_r, data_r, tx_r, rx_r, rbyte_r;
	logic [1:0]               q_r;
	logic [3:0]               bit_r, left_r;
	logic                     addr_ph_r, rd_r, scl_oe_r, sda_oe_r, busy_r, anack_r, dnack_r;
	logic                     tick, sending;

	assign wr_do = aw_got_r & w_got_r & ~bvalid_r;
	assign go    = wr_do & (awaddr_h_r == tsw_pkg::CMD_OFS) & ~busy_r & (&wstrb_h_r[2:0]);

	// write channels, taken in either order
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= tsw_pkg::RESP_OKAY;
			awaddr_h_r <= 8'h00;
			wdata_h_r <= 32'h0;
			wstrb_h_r <= 4'h0;
		end else begin
			if (awready_r && axi_awvalid_in) begin
				awready_r  <= 1'b0;
				aw_got_r   <= 1'b1;
				awaddr_h_r <= axi_awaddr_in;
			end
			if (wready_r && axi_wvalid_in) begin
				wready_r  <= 1'b0;
				w_got_r   <= 1'b1;
				wdata_h_r <= axi_wdata_in;
				wstrb_h_r <= axi_wstrb_in;
			end
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r  <= (awaddr_h_r == tsw_pkg::CMD_OFS || awaddr_h_r == tsw_pkg::STAT_OFS)
					? tsw_pkg::RESP_OKAY : tsw_pkg::RESP_DECERR;
			end
			if (bvalid_r && axi_bready_in) begin
				bvalid_r  <= 1'b0;
				aw_got_r  <= 1'b0;
				w_got_r   <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// read channel
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0;
			rresp_r   <= tsw_pkg::RESP_OKAY;
		end else if (arready_r && axi_arvalid_in) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= 32'h0;
			rresp_r   <= tsw_pkg::RESP_OKAY;
			if (axi_araddr_in == tsw_pkg::STAT_OFS) begin
				rdata_r[tsw_pkg::STAT_BUSY_BIT]  <= busy_r;
				rdata_r[tsw_pkg::STAT_ANACK_BIT] <= anack_r;
				rdata_r[tsw_pkg::STAT_DNACK_BIT] <= dnack_r;
				rdata_r[tsw_pkg::STAT_RDATA_LSB +: 8] <= rbyte_r;
			end else if (axi_araddr_in == tsw_pkg::CMD_OFS) begin
				rdata_r[tsw_pkg::CMD_DATA_LSB +: 8] <= data_r;
			end else begin
				rresp_r <= tsw_pkg::RESP_DECERR;
			end
		end else if (rvalid_r && axi_rready_in) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sda_sy_r <= 2'h3;
		end else begin
			sda_sy_r <= {sda_sy_r[0], bus.sda};
		end
	end

	assign tick    = (qcnt_r == tsw_pkg::QTR_CYC - 8'h01);
	assign sending = ~addr_ph_r ? ~rd_r : 1'b1;

	// link engine: four quarters per bit
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= tsw_pkg::HS_IDLE;
			qcnt_r <= 8'h00;
			q_r <= 2'h0;
			bit_r <= 4'h0;
			left_r <= 4'h0;
			data_r <= 8'h00;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			rbyte_r <= 8'h00;
			addr_ph_r <= 1'b0;
			rd_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			busy_r <= 1'b0;
			anack_r <= 1'b0;
			dnack_r <= 1'b0;
		end else if (st_r == tsw_pkg::HS_IDLE) begin
			qcnt_r <= 8'h00;
			q_r    <= 2'h0;
			if (go) begin
				st_r      <= tsw_pkg::HS_START;
				busy_r    <= 1'b1;
				anack_r   <= 1'b0;
				dnack_r   <= 1'b0;
				data_r    <= wdata_h_r[tsw_pkg::CMD_DATA_LSB +: 8];
				rd_r      <= wdata_h_r[tsw_pkg::CMD_RD_BIT];
				tx_r      <= {wdata_h_r[tsw_pkg::CMD_ADDR_LSB +: 7], wdata_h_r[tsw_pkg::CMD_RD_BIT]};
				left_r    <= (wdata_h_r[tsw_pkg::CMD_CNT_LSB +: 4] == 4'h0) ? 4'h1
					: wdata_h_r[tsw_pkg::CMD_CNT_LSB +: 4];
				addr_ph_r <= 1'b1;
				bit_r     <= 4'h0;
			end
		end else begin
			qcnt_r <= tick ? 8'h00 : qcnt_r + 8'h01;
			if (tick) begin
				q_r <= q_r + 2'h1;
				case (st_r)
					tsw_pkg::HS_START: begin
						if (q_r == 2'h0) sda_oe_r <= 1'b1;
						if (q_r == 2'h3) begin
							scl_oe_r <= 1'b1;
							st_r     <= tsw_pkg::HS_BIT;
						end
					end
					tsw_pkg::HS_BIT: begin
						case (q_r)
							2'h0: sda_oe_r <= (bit_r == tsw_pkg::ACK_SLOT)
								? (~sending && left_r != 4'h1) : (sending & ~tx_r[7]);
							2'h1: scl_oe_r <= 1'b0;
							2'h2: if (bit_r != tsw_pkg::ACK_SLOT) rx_r <= {rx_r[6:0], sda_sy_r[1]};
							default: begin
								scl_oe_r <= 1'b1;
								bit_r    <= bit_r + 4'h1;
								tx_r     <= {tx_r[6:0], 1'b0};
								if (bit_r == tsw_pkg::ACK_SLOT) begin
									bit_r     <= 4'h0;
									tx_r      <= data_r;
									addr_ph_r <= 1'b0;
									if (!addr_ph_r) left_r <= left_r - 4'h1;
									if (!addr_ph_r && rd_r) rbyte_r <= rx_r;
									if (sending && sda_sy_r[1]) begin
										anack_r <= addr_ph_r;
										dnack_r <= ~addr_ph_r;
										st_r    <= tsw_pkg::HS_STOP;
									end else if (!addr_ph_r && left_r == 4'h1) begin
										st_r <= tsw_pkg::HS_STOP;
									end
								end
							end
						endcase
					end
					tsw_pkg::HS_STOP: begin
						case (q_r)
							2'h0: sda_oe_r <= 1'b1;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b0;
							default: begin
								st_r   <= tsw_pkg::HS_IDLE;
								busy_r <= 1'b0;
							end
						endcase
					end
					default: st_r <= tsw_pkg::HS_IDLE;
				endcase
			end
		end
	end

	assign bus.host_scl_out = 1'b0;
	assign bus.host_scl_oe  = scl_oe_r;
	assign bus.host_sda_out = 1'b0;
	assign bus.host_sda_oe  = sda_oe_r;
	assign axi_awready_out  = awready_r;
	assign axi_wready_out   = wready_r;
	assign axi_bvalid_out   = bvalid_r;
	assign axi_bresp_out    = bresp_r;
	assign axi_arready_out  = arready_r;
	assign axi_rvalid_out   = rvalid_r;
	assign axi_rdata_out    = rdata_r;
	assign axi_rresp_out    = rresp_r;
endmodule : tsw_host
`default_nettype wire

// ==== design/tsw_pkg.sv ====
// shared constants and types for the two-wire slave port and its master
package tsw_pkg;
	// device address on the link; value is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h3A;
	localparam int unsigned BYTE_BITS = 8;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// master timing: link clock built from quarter periods
	localparam int unsigned CLK_NS = 4;
	localparam int unsigned SCL_PERIOD_NS = 2500;
	localparam int unsigned QTR_NS = SCL_PERIOD_NS / 4;
	localparam int unsigned QTR_CYC_I = (QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] QTR_CYC = 8'(QTR_CYC_I);
	// master register map
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam int unsigned CMD_DATA_LSB = 0;
	localparam int unsigned CMD_ADDR_LSB = 8;
	localparam int unsigned CMD_RD_BIT = 15;
	localparam int unsigned CMD_CNT_LSB = 16;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_ANACK_BIT = 1;
	localparam int unsigned STAT_DNACK_BIT = 2;
	localparam int unsigned STAT_RDATA_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// serial engine states
	typedef enum logic [5:0] {
		DS_IDLE   = 6'h01,
		DS_RX     = 6'h02,
		DS_RX_ACK = 6'h04,
		DS_TX     = 6'h08,
		DS_TX_ACK = 6'h10,
		DS_IGNORE = 6'h20
	} tsw_dev_state_t;
	typedef enum logic [3:0] {
		HS_IDLE  = 4'h1,
		HS_START = 4'h2,
		HS_BIT   = 4'h4,
		HS_STOP  = 4'h8
	} tsw_host_state_t;
endpackage : tsw_pkg

// ==== design/tsw_if.sv ====
// two-wire link between master and slave port, open-drain resolution
`timescale 1ns/10ps
`default_nettype none
interface tsw_if;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// released lines float high
	assign scl = host_scl_oe ? host_scl_out : 1'b1;
	assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);
	modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_out, output host_scl_oe,
		output host_sda_out, output host_sda_oe);
endinterface : tsw_if
`default_nettype wire

// ==== design/tsw_dev.sv ====
// two-wire slave port with control byte and channel enables
//
// Behaviour
// - master starts only while bus idle
// - one bit per clock, data stable high
// - both lines released high means idle
// - sda falling, scl high is start
// - sda rising, scl high is stop
// - unlimited bytes per transaction
// - ninth clock carries acknowledge slot
// - byte sender releases sda during acknowledge
// - addressed receiver acknowledges every byte
// - master acknowledges all read bytes but last
// - acknowledger holds sda low through pulse
// - master ends read by withholding acknowledge
// - after no acknowledge, release sda
// - write loads control byte, read returns its low nibble
// - last written byte is kept
// - low nibble enables channels after stop
// - read high nibble shows pending interrupts
// - reset clears byte and state machine
`timescale 1ns/10ps
`default_nettype none
module tsw_dev (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	// two-wire link
	tsw_if.device           bus,
	// channel side
	input  wire logic [3:0] channel_interrupt_inputs_b_in,
	output logic      [3:0] channel_enable_bits_out,
	output logic      [7:0] ctrl_byte_out
);
	logic [2:0]                  scl_sy_r;
	logic [2:0]                  sda_sy_r;
	logic [3:0]                  int_s1_r;
	logic [3:0]                  int_s2_r;
	tsw_pkg::tsw_dev_state_t     st_r;
	logic [3:0]                  cnt_r;
	logic [7:0]                  sr_r;
	logic                        addr_ph_r;
	logic                        rw_r;
	logic                        ack_ok_r;
	logic                        sda_oe_r;
	logic [7:0]                  ctrl_r;
	logic [3:0]                  en_r;
	logic                        scl_s;
	logic                        sda_s;
	logic                        scl_rise;
	logic                        scl_fall;
	logic                        start_det;
	logic                        stop_det;
	logic                        wr_stb;
	logic [7:0]                  tx_byte;

	// two-stage synchronisers plus one history stage
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_sy_r <= 3'h7;
			sda_sy_r <= 3'h7;
		end else begin
			scl_sy_r <= {scl_sy_r[1:0], bus.scl};
			sda_sy_r <= {sda_sy_r[1:0], bus.sda};
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			int_s1_r <= 4'hF;
			int_s2_r <= 4'hF;
		end else begin
			int_s1_r <= channel_interrupt_inputs_b_in;
			int_s2_r <= int_s1_r;
		end
	end

	assign scl_s     = scl_sy_r[1];
	assign sda_s     = sda_sy_r[1];
	assign scl_rise  = scl_s & ~scl_sy_r[2];
	assign scl_fall  = ~scl_s & scl_sy_r[2];
	assign start_det = scl_s & scl_sy_r[2] & sda_sy_r[2] & ~sda_s;
	assign stop_det  = scl_s & scl_sy_r[2] & ~sda_sy_r[2] & sda_s;
	// pending interrupts are low pins; channel 0 in bit 4
	assign tx_byte   = {~int_s2_r, ctrl_r[3:0]};
	assign wr_stb    = (st_r == tsw_pkg::DS_RX) & scl_fall & (cnt_r == tsw_pkg::ACK_SLOT)
		& ~addr_ph_r & ~start_det & ~stop_det;

	// serial engine
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r      <= tsw_pkg::DS_IDLE;
			cnt_r     <= 4'h0;
			sr_r      <= 8'h00;
			addr_ph_r <= 1'b0;
			rw_r      <= 1'b0;
			ack_ok_r  <= 1'b0;
			sda_oe_r  <= 1'b0;
		end else if (start_det) begin
			// abandon any byte and count afresh
			st_r      <= tsw_pkg::DS_RX;
			cnt_r     <= 4'h0;
			addr_ph_r <= 1'b1;
			sda_oe_r  <= 1'b0;
		end else if (stop_det) begin
			st_r     <= tsw_pkg::DS_IDLE;
			cnt_r    <= 4'h0;
			sda_oe_r <= 1'b0;
		end else begin
			case (st_r)
				tsw_pkg::DS_RX: begin
					if (scl_rise && cnt_r < tsw_pkg::ACK_SLOT) begin
						sr_r  <= {sr_r[6:0], sda_s};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == tsw_pkg::ACK_SLOT) begin
						if (addr_ph_r) begin
							if (sr_r[7:1] == tsw_pkg::DEV_ADDR) begin
								sda_oe_r  <= 1'b1;
								rw_r      <= sr_r[0];
								addr_ph_r <= 1'b0;
								st_r      <= tsw_pkg::DS_RX_ACK;
							end else begin
								st_r <= tsw_pkg::DS_IGNORE;
							end
						end else begin
							sda_oe_r <= 1'b1;
							st_r     <= tsw_pkg::DS_RX_ACK;
						end
					end
				end
				tsw_pkg::DS_RX_ACK: begin
					// hold low through the ninth pulse; on its fall let go, or for a read drive the first data bit
					if (scl_fall) begin
						cnt_r <= 4'h0;
						if (rw_r) begin
							sr_r     <= tx_byte;
							sda_oe_r <= ~tx_byte[7];
							st_r     <= tsw_pkg::DS_TX;
						end else begin
							sda_oe_r <= 1'b0;
							st_r     <= tsw_pkg::DS_RX;
						end
					end
				end
				tsw_pkg::DS_TX: begin
					if (scl_fall) begin
						if (cnt_r == tsw_pkg::LAST_TX_BIT) begin
							sda_oe_r <= 1'b0;
							cnt_r    <= 4'h0;
							st_r     <= tsw_pkg::DS_TX_ACK;
						end else begin
							cnt_r    <= cnt_r + 4'h1;
							sr_r     <= {sr_r[6:0], 1'b0};
							sda_oe_r <= ~sr_r[6];
						end
					end
				end
				tsw_pkg::DS_TX_ACK: begin
					if (scl_rise) begin
						ack_ok_r <= ~sda_s;
					end else if (scl_fall) begin
						if (ack_ok_r) begin
							sr_r     <= tx_byte;
							sda_oe_r <= ~tx_byte[7];
							st_r     <= tsw_pkg::DS_TX;
						end else begin
							sda_oe_r <= 1'b0;
							st_r     <= tsw_pkg::DS_IGNORE;
						end
					end
				end
				tsw_pkg::DS_IDLE, tsw_pkg::DS_IGNORE: begin
					sda_oe_r <= 1'b0;
				end
				default: begin
					st_r     <= tsw_pkg::DS_IDLE;
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// control byte, every written byte overwrites the last
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_r <= tsw_pkg::CTRL_RST;
		end else if (wr_stb) begin
			ctrl_r <= sr_r;
		end
	end

	// channel enables follow the byte only at stop
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			en_r <= 4'h0;
		end else if (stop_det) begin
			en_r <= ctrl_r[3:0];
		end
	end

	assign bus.dev_sda_out         = 1'b0;
	assign bus.dev_sda_oe          = sda_oe_r;
	assign channel_enable_bits_out = en_r;
	assign ctrl_byte_out           = ctrl_r;
endmodule : tsw_dev
`default_nettype wire

// ==== test/tsw_link_asserts.sv ====
// concurrent checks on the two-wire link between master and slave port
`timescale 1ns/10ps
`default_nettype none
module tsw_link_asserts (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// link signals
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_idx;
	logic [7:0] byte_cnt;
	logic [7:0] shift_r;
	logic       match_r;
	logic       rd_r;
	logic       quiet_r;
	logic       rise;
	logic       start;
	logic       stop;
	logic       slot9;
	assign rise  = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop  = scl & scl_q & ~sda_q & sda;
	assign slot9 = rise & (bit_idx == tsw_pkg::ACK_SLOT);
	// line history
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	// bit slot and byte count since start
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bit_idx  <= 4'h0;
			byte_cnt <= 8'h00;
		end else if (start) begin
			bit_idx  <= 4'h0;
			byte_cnt <= 8'h00;
		end else if (slot9) begin
			bit_idx  <= 4'h0;
			byte_cnt <= byte_cnt + 8'h01;
		end else if (rise) begin
			bit_idx <= bit_idx + 4'h1;
		end
	end
	// address byte capture
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shift_r <= 8'h00;
			match_r <= 1'h0;
			rd_r    <= 1'h0;
		end else if (rise && bit_idx < tsw_pkg::ACK_SLOT) begin
			shift_r <= {shift_r[6:0], sda};
		end else if (slot9 && byte_cnt == 8'h00) begin
			match_r <= (shift_r[7:1] == tsw_pkg::DEV_ADDR);
			rd_r    <= shift_r[0];
		end
	end
	// device must stay silent after foreign address or master refusal
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			quiet_r <= 1'h0;
		end else if (start || stop) begin
			quiet_r <= 1'h0;
		end else if (slot9 && byte_cnt == 8'h00 && shift_r[7:1] != tsw_pkg::DEV_ADDR) begin
			quiet_r <= 1'h1;
		end else if (slot9 && byte_cnt != 8'h00 && match_r && rd_r && sda) begin
			quiet_r <= 1'h1;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	property p_stable;
		(scl && $past(scl)) |-> $stable(dev_sda_oe);
	endproperty
	a_stable: assert property (p_stable) else $error("device sda moved while scl high");
	property p_idle;
		stop |=> (!dev_sda_oe && scl && sda)[*8];
	endproperty
	a_idle: assert property (p_idle) else $error("link not idle after stop");
	property p_addr_quiet;
		(byte_cnt == 8'h00 && bit_idx < tsw_pkg::ACK_SLOT) |-> !dev_sda_oe;
	endproperty
	a_addr_quiet: assert property (p_addr_quiet) else $error("device drove address bits");
	property p_addr_ack;
		(slot9 && byte_cnt == 8'h00) |-> (sda == (shift_r[7:1] != tsw_pkg::DEV_ADDR));
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("wrong address acknowledge");
	property p_wr_ack;
		(slot9 && byte_cnt != 8'h00 && match_r && !rd_r) |-> !sda;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("write byte not acknowledged");
	property p_rd_release;
		(slot9 && byte_cnt != 8'h00 && match_r && rd_r) |-> !dev_sda_oe;
	endproperty
	a_rd_release: assert property (p_rd_release) else $error("device held ack slot");
	property p_quiet;
		quiet_r |-> !dev_sda_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("device drove sda when silent");
	property p_ack_hold;
		($rose(scl) && dev_sda_oe) |-> (dev_sda_oe && scl)[*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("low not held in pulse");
	property p_open_drain;
		dev_sda_oe |-> (!dev_sda_out && !sda);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("driven sda not low");
	property p_reset;
		$rose(rst_b_in) |-> (!dev_sda_oe)[*3];
	endproperty
	a_reset: assert property (p_reset) else $error("device drove sda after reset");
	c_nack: cover property (slot9 && byte_cnt != 8'h00 && match_r && rd_r && sda);
	c_foreign: cover property (slot9 && byte_cnt == 8'h00 && shift_r[7:1] != tsw_pkg::DEV_ADDR);
	c_stop: cover property (stop);
	c_wr_ack: cover property (slot9 && byte_cnt != 8'h00 && match_r && !rd_r);
endmodule : tsw_link_asserts
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for master and slave port joined over the link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int LIMIT = 95000;
	logic        clk_in;
	logic        rst_b_in;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        aw_rdy;
	logic [31:0] wdata;
	logic        wvalid;
	logic        w_rdy;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        ar_rdy;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [3:0]  irq_b;
	logic [3:0]  enables;
	logic [7:0]  ctrl;
	int          err_total;
	int          checks;
	int          cycles;
	tsw_if tsw_if_inst ();
	tsw_dev tsw_dev_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus(tsw_if_inst),
		.channel_interrupt_inputs_b_in(irq_b), .channel_enable_bits_out(enables),
		.ctrl_byte_out(ctrl));
	tsw_host tsw_host_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .axi_awaddr_in(awaddr),
		.axi_awvalid_in(awvalid), .axi_awready_out(aw_rdy), .axi_wdata_in(wdata),
		.axi_wstrb_in(4'hF), .axi_wvalid_in(wvalid), .axi_wready_out(w_rdy),
		.axi_bresp_out(bresp), .axi_bvalid_out(bvalid), .axi_bready_in(bready),
		.axi_araddr_in(araddr), .axi_arvalid_in(arvalid), .axi_arready_out(ar_rdy),
		.axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
		.axi_rready_in(rready), .bus(tsw_if_inst));
	tsw_link_asserts tsw_link_asserts_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.scl(tsw_if_inst.scl), .sda(tsw_if_inst.sda),
		.dev_sda_out(tsw_if_inst.dev_sda_out), .dev_sda_oe(tsw_if_inst.dev_sda_oe));
	always #2 clk_in = ~clk_in;
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk_val
	task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk_resp
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		awaddr  <= a;
		awvalid <= 1'h1;
		wdata   <= d;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do begin
			@(posedge clk_in);
			if (awvalid && aw_rdy) awvalid <= 1'h0;
			if (wvalid && w_rdy) wvalid <= 1'h0;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'h0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do begin
			@(posedge clk_in);
			if (arvalid && ar_rdy) arvalid <= 1'h0;
		end while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask : axi_rd
	task automatic send_cmd(input logic [6:0] a, input logic rd, input logic [3:0] n,
		input logic [7:0] d);
		logic [1:0] r;
		axi_wr(tsw_pkg::CMD_OFS, {12'h000, n, rd, a, d}, r);
		chk_resp("cmd resp", tsw_pkg::RESP_OKAY, r);
	endtask : send_cmd
	task automatic wait_idle(output logic [31:0] st);
		logic [1:0] r;
		st = 32'h1;
		while (st[tsw_pkg::STAT_BUSY_BIT]) begin
			repeat (100) @(posedge clk_in);
			axi_rd(tsw_pkg::STAT_OFS, st, r);
		end
	endtask : wait_idle
	task automatic t_reset;
		logic [31:0] st;
		logic [1:0]  r;
		chk_val("ctrl", {24'h0, tsw_pkg::CTRL_RST}, {24'h0, ctrl});
		chk_val("enables", 32'h0, {28'h0, enables});
		axi_rd(tsw_pkg::STAT_OFS, st, r);
		chk_val("status", 32'h0, st);
		$display("test reset done");
	endtask : t_reset
	task automatic t_write;
		logic [31:0] st;
		send_cmd(tsw_pkg::DEV_ADDR, 1'h0, 4'h3, 8'hC6);
		send_cmd(tsw_pkg::DEV_ADDR, 1'h0, 4'h1, 8'h55);
		repeat (13000) @(posedge clk_in);
		chk_val("ctrl before stop", 32'hC6, {24'h0, ctrl});
		chk_val("enables before stop", 32'h0, {28'h0, enables});
		wait_idle(st);
		chk_val("write flags", 32'h0, {29'h0, st[2:0]});
		chk_val("ctrl", 32'hC6, {24'h0, ctrl});
		chk_val("enables", 32'h6, {28'h0, enables});
		$display("test write done");
	endtask : t_write
	task automatic t_read;
		logic [31:0] st;
		@(posedge clk_in);
		irq_b <= 4'h6;
		send_cmd(tsw_pkg::DEV_ADDR, 1'h1, 4'h2, 8'h00);
		wait_idle(st);
		chk_val("read byte", 32'h96, {24'h0, st[15:8]});
		chk_val("read anack", 32'h0, {31'h0, st[tsw_pkg::STAT_ANACK_BIT]});
		chk_val("ctrl kept", 32'hC6, {24'h0, ctrl});
		$display("test read done");
	endtask : t_read
	task automatic t_foreign;
		logic [31:0] st;
		send_cmd(tsw_pkg::DEV_ADDR ^ 7'h01, 1'h0, 4'h1, 8'h0F);
		wait_idle(st);
		chk_val("foreign anack", 32'h1, {31'h0, st[tsw_pkg::STAT_ANACK_BIT]});
		chk_val("ctrl kept", 32'hC6, {24'h0, ctrl});
		chk_val("enables kept", 32'h6, {28'h0, enables});
		$display("test foreign done");
	endtask : t_foreign
	task automatic t_decode;
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(8'h08, 32'h0000_00FF, r);
		chk_resp("unmapped write", tsw_pkg::RESP_DECERR, r);
		axi_rd(8'h08, d, r);
		chk_resp("unmapped read", tsw_pkg::RESP_DECERR, r);
		chk_val("unmapped data", 32'h0, d);
		axi_rd(tsw_pkg::CMD_OFS, d, r);
		chk_resp("cmd read", tsw_pkg::RESP_OKAY, r);
		chk_val("cmd data", 32'h0F, d);
		$display("test decode done");
	endtask : t_decode
	task automatic t_midreset;
		logic [31:0] st;
		logic [1:0]  r;
		send_cmd(tsw_pkg::DEV_ADDR, 1'h0, 4'h1, 8'h03);
		repeat (8000) @(posedge clk_in);
		rst_b_in <= 1'h0;
		repeat (5) @(posedge clk_in);
		chk_val("ctrl in reset", 32'h0, {24'h0, ctrl});
		chk_val("enables in reset", 32'h0, {28'h0, enables});
		rst_b_in <= 1'h1;
		repeat (5) @(posedge clk_in);
		axi_rd(tsw_pkg::STAT_OFS, st, r);
		chk_val("status after reset", 32'h0, st);
		$display("test midreset done");
	endtask : t_midreset
	initial begin
		clk_in = 1'h0;
		rst_b_in = 1'h0;
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		irq_b = 4'hF;
		err_total = 0;
		checks = 0;
		cycles = 0;
		repeat (5) @(posedge clk_in);
		rst_b_in <= 1'h1;
		repeat (5) @(posedge clk_in);
		fork
			begin
				t_reset();
				t_write();
				t_read();
				t_foreign();
				t_decode();
				t_midreset();
			end
			begin
				while (cycles < LIMIT) begin
					@(posedge clk_in);
					cycles++;
				end
				err_total++;
				$display("[FAIL] run cycles expected below %0d seen %0d", LIMIT, cycles);
			end
		join_any
		test_done();
	end
endmodule : tb_top
`default_nettype wire
